// >>> logic/alm_filter_entry.sv
// one filter_entry: apb configuration and l4 / ethertype hit logic
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module alm_filter_entry
    import alm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hdr_valid,
    input wire logic hdr_is_ip,
    input wire logic hdr_is_tcp,
    input wire logic hdr_is_udp,
    input wire logic [15:0] hdr_etype,
    input wire logic [15:0] hdr_sport,
    input wire logic [15:0] hdr_dport,
    input wire logic [5:0] hdr_flags,
    output logic hit_valid,
    output logic hit
);
    // configuration state
    logic [ALM_CTRL_W-1:0] ctrl; // enable, frame type, modes
    logic [31:0] sport_cfg; // source exact/low and high
    logic [31:0] dport_cfg; // destination exact/low and high
    logic [11:0] flags_cfg; // two bits per tcp flag
    logic [15:0] etype_cfg; // exact ethertype
    logic [15:0] hit_cnt; // saturating hit count

    // decoded apb phases
    logic wr_go; // write takes effect
    logic rd_go; // read data taken
    logic addr_ok; // address is mapped
    logic [4:0] off; // byte offset within block

    // per-criterion verdicts
    logic is_l4; // tcp or udp frame
    logic ft_ok; // frame type selector satisfied
    logic et_ok; // ethertype criterion satisfied
    logic [ALM_NFLAG-1:0] flag_ok; // each tcp flag satisfied
    logic next_hit; // combined verdict

    alm_port_if sp_if ();
    alm_port_if dp_if ();

    assign off = paddr[4:0];
    assign addr_ok = (paddr[31:5] == 27'h0000000) && (off == ALM_OFF_CTRL ||
        off == ALM_OFF_SPORT || off == ALM_OFF_DPORT || off == ALM_OFF_FLAGS ||
        off == ALM_OFF_ETYPE || off == ALM_OFF_STAT);
    assign wr_go = psel && penable && pwrite && addr_ok;
    assign rd_go = psel && penable && !pwrite;
    // zero wait states, unmapped access flagged
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= '0;
        else if (wr_go && off == ALM_OFF_CTRL)
            ctrl <= pwdata[ALM_CTRL_W-1:0];
    end

    // port configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sport_cfg <= '0;
            dport_cfg <= '0;
        end
        else if (wr_go)
        begin
            if (off == ALM_OFF_SPORT)
                sport_cfg <= pwdata;
            if (off == ALM_OFF_DPORT)
                dport_cfg <= pwdata;
        end
    end

    // flag settings, reset to any for every flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_cfg <= ALM_FLAGS_RST;
        else if (wr_go && off == ALM_OFF_FLAGS)
            flags_cfg <= pwdata[11:0];
    end

    // ethertype value; a write below the legal floor is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            etype_cfg <= ALM_ETYPE_RST;
        else if (wr_go && off == ALM_OFF_ETYPE && pwdata[15:0] >= ALM_ETYPE_MIN)
            etype_cfg <= pwdata[15:0];
    end

    // read data register, zero for unmapped or reserved bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= '0;
            unique case (off)
                ALM_OFF_CTRL: prdata[ALM_CTRL_W-1:0] <= ctrl;
                ALM_OFF_SPORT: prdata <= sport_cfg;
                ALM_OFF_DPORT: prdata <= dport_cfg;
                ALM_OFF_FLAGS: prdata[11:0] <= flags_cfg;
                ALM_OFF_ETYPE: prdata[15:0] <= etype_cfg;
                ALM_OFF_STAT: prdata <= {hit_cnt, 15'h0000, hit};
                default: prdata <= '0;
            endcase
            if (paddr[31:5] != 27'h0000000)
                prdata <= '0;
        end
    end

    // source port criterion
    assign sp_if.mode = ctrl[ALM_CTRL_SP +: 2];
    assign sp_if.lo = sport_cfg[15:0];
    assign sp_if.hi = sport_cfg[ALM_HI_LSB +: 16];
    assign sp_if.port = hdr_sport;
    alm_port_match u_sp (.pif(sp_if.match));

    // destination port criterion
    assign dp_if.mode = ctrl[ALM_CTRL_DP +: 2];
    assign dp_if.lo = dport_cfg[15:0];
    assign dp_if.hi = dport_cfg[ALM_HI_LSB +: 16];
    assign dp_if.port = hdr_dport;
    alm_port_match u_dp (.pif(dp_if.match));

    // ethertype criterion, live only for ethertype-class entries
    alm_etype_match u_et
    (
        .active(ctrl[ALM_CTRL_FT +: 2] == ALM_FT_ETYPE),
        .exact(ctrl[ALM_CTRL_ET]),
        .value(etype_cfg),
        .etype(hdr_etype),
        .ok(et_ok)
    );

    // per-flag check: a non-any setting needs a tcp frame with that level
    genvar gi;
    generate
        for (gi = 0; gi < ALM_NFLAG; gi++)
        begin : g_flag
            logic [1:0] code; // this flag's setting
            assign code = flags_cfg[2*gi +: 2];
            always_comb
            begin
                if (code == ALM_FLAG_SET)
                    flag_ok[gi] = hdr_is_tcp && hdr_flags[gi];
                else if (code == ALM_FLAG_CLR)
                    flag_ok[gi] = hdr_is_tcp && !hdr_flags[gi];
                else
                    flag_ok[gi] = 1'b1; // any
            end
        end
    endgenerate

    assign is_l4 = hdr_is_tcp || hdr_is_udp;

    // frame type selector
    always_comb
    begin
        unique case (alm_ftype_t'(ctrl[ALM_CTRL_FT +: 2]))
            ALM_FT_ETYPE: ft_ok = !hdr_is_ip;
            ALM_FT_IP: ft_ok = hdr_is_ip;
            ALM_FT_ANY: ft_ok = 1'b1;
            default: ft_ok = 1'b1;
        endcase
    end

    // combined verdict: every criterion at once, ports only on l4 frames
    always_comb
    begin
        next_hit = ctrl[ALM_CTRL_EN] && ft_ok && et_ok && (&flag_ok);
        // only exact and range demand an l4 frame; the spare mode code acts as any
        if (sp_if.mode inside {ALM_PM_EXACT, ALM_PM_RANGE} && !(is_l4 && sp_if.ok))
            next_hit = 1'b0;
        if (dp_if.mode inside {ALM_PM_EXACT, ALM_PM_RANGE} && !(is_l4 && dp_if.ok))
            next_hit = 1'b0;
    end

    // one-cycle result pulse per parsed header
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hit_valid <= 1'b0;
        else
            hit_valid <= hdr_valid;
    end

    // hit level holds the last verdict
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hit <= 1'b0;
        else if (hdr_valid)
            hit <= next_hit;
    end

    // saturating hit counter for status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hit_cnt <= '0;
        else if (hdr_valid && next_hit && hit_cnt != 16'hFFFF)
            hit_cnt <= hit_cnt + 16'h0001;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // header presented, result one cycle later
    sequence hdr_s;
        hdr_valid;
    endsequence
    sequence res_s;
        ##1 hit_valid;
    endsequence

    sp_any_a: assert property (
        sp_if.mode == ALM_PM_ANY |-> sp_if.ok)
        else $error("source any did not pass");
    sp_exact_a: assert property (
        hdr_valid && sp_if.mode == ALM_PM_EXACT && hdr_sport != sport_cfg[15:0]
        |=> hit_valid && !hit)
        else $error("source exact mismatch hit");
    sp_range_a: assert property (
        hdr_valid && sp_if.mode == ALM_PM_RANGE && hdr_sport > sport_cfg[31:16]
        |=> !hit)
        else $error("source above range hit");
    dp_any_a: assert property (
        dp_if.mode == ALM_PM_ANY |-> dp_if.ok)
        else $error("destination any did not pass");
    dp_exact_a: assert property (
        hdr_valid && dp_if.mode == ALM_PM_EXACT && hdr_dport != dport_cfg[15:0]
        |=> !hit)
        else $error("destination exact mismatch hit");
    dp_range_a: assert property (
        hdr_valid && dp_if.mode == ALM_PM_RANGE && hdr_dport < dport_cfg[15:0]
        |=> !hit)
        else $error("destination below range hit");
    flag_set_a: assert property (
        hdr_valid && ((flags_cfg[0 +: 2] == ALM_FLAG_SET && !hdr_flags[0]) ||
        (flags_cfg[2 +: 2] == ALM_FLAG_CLR && hdr_flags[1])) |=> !hit)
        else $error("tcp flag setting ignored");
    etype_a: assert property (
        hdr_valid && ctrl[ALM_CTRL_FT +: 2] == ALM_FT_ETYPE && ctrl[ALM_CTRL_ET] &&
        hdr_etype != etype_cfg |=> !hit)
        else $error("ethertype mismatch hit");
    etype_any_a: assert property (
        !ctrl[ALM_CTRL_ET] |-> et_ok)
        else $error("ethertype any rejected");
    etype_floor_a: assert property (
        etype_cfg >= ALM_ETYPE_MIN)
        else $error("ethertype below floor stored");
    hit_cause_a: assert property (
        hdr_s ##0 !ctrl[ALM_CTRL_EN] |-> res_s ##0 !hit)
        else $error("disabled entry hit");
    hit_hold_a: assert property (
        !hdr_valid |=> !hit_valid && $stable(hit))
        else $error("result changed without header");
    // every header gets exactly one result pulse a cycle later
    hit_pulse_a: assert property (
        hdr_s |-> res_s)
        else $error("no result after header");
    // lower bound of the source range is inclusive, nothing below passes
    sp_range_lo_a: assert property (
        hdr_valid && sp_if.mode == ALM_PM_RANGE && hdr_sport < sport_cfg[15:0]
        |=> !hit)
        else $error("source below range hit");
    // upper bound of the destination range is inclusive, nothing above passes
    dp_range_hi_a: assert property (
        hdr_valid && dp_if.mode == ALM_PM_RANGE && hdr_dport > dport_cfg[31:16]
        |=> !hit)
        else $error("destination above range hit");
    // an exact source port criterion never passes a frame without tcp or udp
    port_l4_a: assert property (
        hdr_valid && sp_if.mode == ALM_PM_EXACT && !hdr_is_tcp && !hdr_is_udp
        |=> !hit)
        else $error("port criterion passed a non l4 frame");
endmodule

// >>> logic/alm_pkg.sv
// constants and types shared by the l4 / ethertype filter entry
package alm_pkg;
    // apb register byte offsets
    localparam logic [4:0] ALM_OFF_CTRL = 5'h00;
    localparam logic [4:0] ALM_OFF_SPORT = 5'h04;
    localparam logic [4:0] ALM_OFF_DPORT = 5'h08;
    localparam logic [4:0] ALM_OFF_FLAGS = 5'h0C;
    localparam logic [4:0] ALM_OFF_ETYPE = 5'h10;
    localparam logic [4:0] ALM_OFF_STAT = 5'h14;
    // control register field positions
    localparam int ALM_CTRL_EN = 0;
    localparam int ALM_CTRL_FT = 1;
    localparam int ALM_CTRL_SP = 3;
    localparam int ALM_CTRL_DP = 5;
    localparam int ALM_CTRL_ET = 7;
    localparam int ALM_CTRL_W = 8;
    // port registers: low bound / exact value low half, high bound high half
    localparam int ALM_HI_LSB = 16;
    // six tcp flags, two bits each: fin syn rst psh ack urg
    localparam int ALM_NFLAG = 6;
    localparam logic [1:0] ALM_FLAG_CLR = 2'h0;
    localparam logic [1:0] ALM_FLAG_SET = 2'h1;
    localparam logic [11:0] ALM_FLAGS_RST = 12'hAAA;
    // smallest legal ethertype value
    localparam logic [15:0] ALM_ETYPE_MIN = 16'h0600;
    localparam logic [15:0] ALM_ETYPE_RST = 16'h0600;
    // status: last hit in bit 0, saturating hit count in upper half
    localparam int ALM_STAT_CNT = 16;
    // port criterion modes
    typedef enum logic [1:0] {ALM_PM_ANY, ALM_PM_EXACT, ALM_PM_RANGE} alm_pmode_t;
    // frame type selector
    typedef enum logic [1:0] {ALM_FT_ANY, ALM_FT_ETYPE, ALM_FT_IP} alm_ftype_t;
endpackage

// >>> logic/alm_port_if.sv
// one port criterion: configuration, frame port and verdict
`timescale 1ns/1ps
interface alm_port_if;
    logic [1:0] mode; // criterion mode code
    logic [15:0] lo; // exact value or low bound
    logic [15:0] hi; // high bound
    logic [15:0] port; // port from the frame
    logic ok; // criterion satisfied
    modport match (input mode, input lo, input hi, input port, output ok);
    modport user (output mode, output lo, output hi, output port, input ok);
endinterface

// >>> logic/alm_port_match.sv
// any / exact / range compare of one tcp or udp port
`timescale 1ns/1ps
module alm_port_match
    import alm_pkg::*;
(
    alm_port_if.match pif
);
    // verdict of the selected mode
    always_comb
    begin
        unique case (alm_pmode_t'(pif.mode))
            ALM_PM_EXACT: pif.ok = (pif.port == pif.lo);
            ALM_PM_RANGE: pif.ok = (pif.port >= pif.lo) && (pif.port <= pif.hi);
            ALM_PM_ANY: pif.ok = 1'b1;
            default: pif.ok = 1'b1; // unused code behaves as any
        endcase
    end
endmodule

// >>> logic/alm_etype_match.sv
// ethertype criterion, only consulted for ethertype-class entries
`timescale 1ns/1ps
module alm_etype_match
    import alm_pkg::*;
(
    input wire logic active,
    input wire logic exact,
    input wire logic [15:0] value,
    input wire logic [15:0] etype,
    output logic ok
);
    // inactive or any: pass; exact: equality only
    always_comb
    begin
        ok = !active || !exact || (etype == value);
    end
endmodule

// >>> tb/alm_hdr_model.sv
// behavioural model of the ingress header parser that feeds one filter entry
`timescale 1ns/1ps
module alm_hdr_model
(
    input wire logic pclk,
    output logic hdr_valid,
    output logic hdr_is_ip,
    output logic hdr_is_tcp,
    output logic hdr_is_udp,
    output logic [15:0] hdr_etype,
    output logic [15:0] hdr_sport,
    output logic [15:0] hdr_dport,
    output logic [5:0] hdr_flags
);
    // idle parser: no header, fields at a neutral level
    initial
    begin
        hdr_valid = 1'b0;
        {hdr_is_ip, hdr_is_tcp, hdr_is_udp, hdr_flags} = 9'h000;
        {hdr_etype, hdr_sport, hdr_dport} = 48'h0;
    end
    // one header pulse; k holds ip, tcp, udp from high bit down
    task automatic send(input logic [2:0] k, input logic [15:0] et, input logic [15:0] sp,
        input logic [15:0] dp, input logic [5:0] fl);
        @(posedge pclk);
        hdr_valid <= 1'b1;
        {hdr_is_ip, hdr_is_tcp, hdr_is_udp} <= k;
        {hdr_etype, hdr_sport, hdr_dport, hdr_flags} <= {et, sp, dp, fl};
        @(posedge pclk);
        hdr_valid <= 1'b0;
        // stale fields flip so a late sample can never match by luck
        {hdr_is_ip, hdr_is_tcp, hdr_is_udp} <= ~k;
        {hdr_etype, hdr_sport, hdr_dport, hdr_flags} <= ~{et, sp, dp, fl};
    endtask
endmodule

// >>> tb/tb_alm_filter_entry.sv
// self-checking bench for the l4 / ethertype filter entry
`timescale 1ns/1ps
module tb_alm_filter_entry import alm_pkg::*;;
    logic pclk = 1'b0; // 250 MHz bus clock
    logic presetn = 1'b0; // active low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, hit_valid, hit;
    logic hdr_valid, hdr_is_ip, hdr_is_tcp, hdr_is_udp;
    logic [15:0] hdr_etype, hdr_sport, hdr_dport;
    logic [5:0] hdr_flags;
    // mirror of the configuration, used for expectations
    logic [7:0] m_ctrl = 8'h00;
    logic [31:0] m_sp = 32'h0, m_dp = 32'h0, rd;
    logic [11:0] m_fl = 12'hAAA;
    logic [15:0] m_et = 16'h0600, cnt = 16'h0;
    logic last = 1'b0, er;
    int num_errors = 0, comparisons = 0;
    logic [15:0] pv [9] = '{16'h0, 16'h1, 16'h63, 16'h64, 16'hC8, 16'hC9, 16'hFFFD, 16'hFFFE,
        16'hFFFF};
    logic [7:0] cv [4] = '{8'h09, 8'h11, 8'h21, 8'h41};
    logic [31:0] rv [4] = '{32'h0000FFFF, 32'h00C80064, 32'h0, 32'hFFFE0001};
    logic [7:0] ec [9] = '{8'h83, 8'h83, 8'h83, 8'h03, 8'h81, 8'h85, 8'h85, 8'h01, 8'h7F};
    logic [2:0] ek [9] = '{3'b010, 3'b010, 3'b110, 3'b001, 3'b000, 3'b110, 3'b010, 3'b100,
        3'b100};
    logic [15:0] ee [9] = '{16'h88CC, 16'h88CD, 16'h88CC, 16'h1234, 16'h1234, 16'h0800,
        16'h88CC, 16'h86DD, 16'h1234};

    always #2 pclk = ~pclk;

    alm_filter_entry DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr_is_ip(hdr_is_ip),
        .hdr_is_tcp(hdr_is_tcp), .hdr_is_udp(hdr_is_udp), .hdr_etype(hdr_etype),
        .hdr_sport(hdr_sport), .hdr_dport(hdr_dport), .hdr_flags(hdr_flags),
        .hit_valid(hit_valid), .hit(hit));
    alm_hdr_model PRT (.pclk(pclk), .hdr_valid(hdr_valid), .hdr_is_ip(hdr_is_ip),
        .hdr_is_tcp(hdr_is_tcp), .hdr_is_udp(hdr_is_udp), .hdr_etype(hdr_etype),
        .hdr_sport(hdr_sport), .hdr_dport(hdr_dport), .hdr_flags(hdr_flags));

    // prints the counts and the verdict, then stops
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // four-state compare
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {27'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // access phase lasts until the slave answers; only the watchdog ends a hang
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        check(pready, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // track what the entry should now hold
        if (w)
            case (a)
                ALM_OFF_CTRL: m_ctrl = d[7:0];
                ALM_OFF_SPORT: m_sp = d;
                ALM_OFF_DPORT: m_dp = d;
                ALM_OFF_FLAGS: m_fl = d[11:0];
                ALM_OFF_ETYPE: if (d[15:0] >= ALM_ETYPE_MIN) m_et = d[15:0];
                default: ;
            endcase
    endtask
    // one port criterion: any, exact, inclusive range
    function automatic logic pok(input logic [1:0] m, input logic [31:0] c, input logic l4,
        input logic [15:0] p);
        if (m == 2'h1) return l4 && p == c[15:0];
        if (m == 2'h2) return l4 && p >= c[15:0] && p <= c[31:16];
        return 1'b1;
    endfunction
    // expected verdict from the mirrored configuration
    function automatic logic exp_hit(input logic [2:0] k, input logic [15:0] et,
        input logic [15:0] sp, input logic [15:0] dp, input logic [5:0] fl);
        logic ok;
        ok = m_ctrl[0] && pok(m_ctrl[4:3], m_sp, |k[1:0], sp) && pok(m_ctrl[6:5], m_dp, |k[1:0], dp);
        if (m_ctrl[2:1] == 2'h1 && (k[2] || (m_ctrl[7] && et != m_et))) ok = 1'b0;
        if (m_ctrl[2:1] == 2'h2 && !k[2]) ok = 1'b0;
        for (int i = 0; i < ALM_NFLAG; i++)
            if (!m_fl[2*i+1] && !(k[1] && fl[i] == m_fl[2*i])) ok = 1'b0;
        return ok;
    endfunction
    // sends one header and checks the verdict one cycle later
    task automatic frame(input logic [2:0] k, input logic [15:0] et, input logic [15:0] sp,
        input logic [15:0] dp, input logic [5:0] fl);
        logic e;
        e = exp_hit(k, et, sp, dp, fl);
        PRT.send(k, et, sp, dp, fl);
        #1;
        check(hit_valid, 32'h1);
        check(hit, e);
        cnt = cnt + e;
        last = e;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        #40000;
        num_errors++;
        complete_run();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ALM_OFF_FLAGS, 32'h0);
        check(rd, 32'h0AAA);
        apb(1'b0, ALM_OFF_ETYPE, 32'h0);
        check(rd, 32'h0600);
        apb(1'b1, 5'h18, 32'h5);
        check(er, 32'h1);
        frame(3'b010, 16'h0800, 16'h1, 16'h2, 6'h0);
        apb(1'b1, ALM_OFF_CTRL, 32'h1);
        frame(3'b110, 16'h0800, 16'h1234, 16'hFFFF, 6'h3F);
        frame(3'b000, 16'h88B5, 16'h0, 16'h0, 6'h3F);
        // exact and range on both ports, boundary values around each bound
        for (int j = 0; j < 4; j++)
        begin
            apb(1'b1, (j < 2) ? ALM_OFF_SPORT : ALM_OFF_DPORT, rv[j]);
            apb(1'b1, ALM_OFF_CTRL, {24'h0, cv[j]});
            foreach (pv[i]) frame({2'b01, i[0]}, 16'h0800, pv[i], pv[i], 6'h0);
            frame(3'b100, 16'h0800, pv[8], pv[8], 6'h0);
        end
        // each flag: must-be-clear then must-be-set, others any
        apb(1'b1, ALM_OFF_CTRL, 32'h1);
        for (int i = 0; i < ALM_NFLAG; i++)
            for (int v = 0; v < 2; v++)
            begin
                apb(1'b1, ALM_OFF_FLAGS, (32'hAAA & ~(32'h3 << 2*i)) | (v << 2*i));
                frame(3'b010, 16'h0800, 16'h1, 16'h2, 6'h1 << i);
                frame(3'b010, 16'h0800, 16'h1, 16'h2, ~(6'h1 << i));
                frame(3'b001, 16'h0800, 16'h1, 16'h2, 6'h1 << i);
            end
        apb(1'b1, ALM_OFF_FLAGS, 32'hAAA);
        // ethertype value outside the reserved ip, arp and ipv6 codes
        apb(1'b1, ALM_OFF_ETYPE, 32'h88CC);
        apb(1'b1, ALM_OFF_ETYPE, 32'h05FF);
        apb(1'b0, ALM_OFF_ETYPE, 32'h0);
        check(rd, 32'h88CC);
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b1, ALM_OFF_CTRL, {24'h0, ec[i]});
            frame(ek[i], ee[i], 16'h7, 16'h8, 6'h0);
        end
        apb(1'b0, ALM_OFF_STAT, 32'h0);
        check(rd, {cnt, 15'h0, last});
        complete_run();
    end
endmodule
